/* resc_startup_config.sv */
// Enable sequencing, soft start, on-time and configuration latching with link slave
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser, output follows once stages two and three agree
module resc_sync3 #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire  [W-1:0] differ = s2 ^ s3;

	// Stage one feeds only stage two
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end
		else
		begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= (s2 & ~differ) | (dout & differ);
		end
	end
endmodule : resc_sync3

// Operation
// - Link accesses are served once bias supply exceeds 3.7 V, switching or not.
// - Power stage switches only after enable has been asserted.
// - Soft start needs bias above start threshold and enable above its threshold.
// - Bus enable source config combines with operating command for hardware/software enable.
// - Mode bit one selects forced continuous, zero selects diode emulation.
// - Mode changes apply only after enable or bias is cycled.
// - Diode emulation stops sync switch near zero current; continuous keeps synchronous.
// - Frequency register accepts 400 kHz to 2 MHz, 200 kHz steps, not 1600.
// - Eight strap options set frequency and mode, latched until enable/bias cycle.
// - Strap applies only when both override bits are zero, else registers.
// - High-side on-time is output over input voltage divided by frequency, continuously.
// - Fixed on-time pulse starts when output falls below floor plus ramp.
// - During soft start the target ramps from zero to set over rise time.
// - Rise ramp starts only after the turn-on delay has elapsed.
// - Load-line code spans 0 to 10 mOhm at 19.53 uOhm steps.
// - Range bit widens load-line to 0 to 50 mOhm at 100 uOhm steps.
// - Four-bit field sets load-line bandwidth 30 kHz steps up to 480 kHz.
// - Telemetry of voltages, currents, powers and temperature is readable.
// - Management link is a two-wire clock and data bus up to 1 MHz.
module resc_startup_config #(
	parameter int MS_CYC = resc_pkg::MS_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               linkClk,
	input  wire logic               sdaIn,
	output var  logic               sdaOut,
	output var  logic               sdaOe,
	input  wire logic               biasAboveStart,
	input  wire logic               biasAboveStop,
	input  wire logic               enableAboveStart,
	input  wire logic               voutBelowRamp,
	input  wire logic               inductorNearZero,
	input  wire logic [2:0]         tonModeStrap,
	input  wire logic [11:0]        voutSense,
	input  wire logic [11:0]        vinSense,
	input  wire resc_pkg::resc_tele_t tele,
	output var  logic               switchEnable,
	output var  logic               softStartActive,
	output var  logic [7:0]         rampLevel,
	output var  logic               highSideOn,
	output var  logic               lowSideOn,
	output var  logic [15:0]        onTimeCycles,
	output var  resc_pkg::resc_latch_t held,
	output var  logic [15:0]        droopCode,
	output var  logic               droopWide,
	output var  logic [8:0]         droopBwKhz,
	output var  logic               analogStayOn
);
	localparam int RAMP_DIV = MS_CYC / resc_pkg::RAMP_STEPS;

	// Link domain state
	resc_pkg::resc_lnk_t lState;
	logic [4:0]  lCnt;
	logic [16:0] lHdr;
	logic [15:0] lData;
	logic [15:0] lOut;
	logic        wrTog;
	logic        rdTog;
	// Core domain registers
	logic [15:0] regMode;
	logic [15:0] regOvr;
	logic [15:0] regDrCfg;
	logic [15:0] regApd;
	logic [7:0]  regOper;
	logic [7:0]  regOnOff;
	logic [15:0] regDroop;
	logic [15:0] regFreq;
	logic [15:0] regTDelay;
	logic [15:0] regTRise;
	logic [15:0] rdHold;
	logic        wrTogD;
	logic        rdTogD;
	logic        biasOk;
	logic        biasOkD;
	logic        armed;
	resc_pkg::resc_seq_t seqState;
	resc_pkg::resc_seq_t next_seqState;
	logic [31:0] seqCnt;
	logic [27:0] divNum;
	logic [28:0] divRem;
	logic [27:0] divQuo;
	logic [22:0] divDen;
	logic [4:0]  divCnt;
	logic [15:0] hsCnt;
	logic [9:0]  syncd;

	// Link domain: frame opens on data low, header is read flag then 16 address bits
	always_ff @(posedge linkClk or posedge rst)
	begin
		if (rst)
		begin
			lState <= resc_pkg::LNK_IDLE;
			lCnt   <= 5'h00;
			lHdr   <= 17'h00000;
			lData  <= 16'h0000;
			lOut   <= 16'h0000;
			wrTog  <= 1'b0;
			rdTog  <= 1'b0;
			sdaOut <= 1'b1;
			sdaOe  <= 1'b0;
		end
		else
		begin
			case (lState)
				resc_pkg::LNK_IDLE:
				begin
					lCnt <= 5'h00;
					if (!sdaIn)
						lState <= resc_pkg::LNK_HDR;
				end
				resc_pkg::LNK_HDR:
				begin
					lHdr <= {lHdr[15:0], sdaIn};
					lCnt <= lCnt + 5'h01;
					if (lCnt == 5'(resc_pkg::HDR_BITS - 1))
					begin
						lCnt <= 5'h00;
						if (lHdr[15])
						begin
							rdTog  <= ~rdTog; // Ask core for the word
							lState <= resc_pkg::LNK_TURN;
						end
						else
							lState <= resc_pkg::LNK_WDATA;
					end
				end
				resc_pkg::LNK_WDATA:
				begin
					lData <= {lData[14:0], sdaIn};
					lCnt  <= lCnt + 5'h01;
					if (lCnt == 5'(resc_pkg::DATA_BITS - 1))
					begin
						wrTog  <= ~wrTog; // Data stands still until next frame
						lState <= resc_pkg::LNK_IDLE;
					end
				end
				resc_pkg::LNK_TURN:
				begin
					lCnt <= lCnt + 5'h01;
					if (lCnt == 5'(resc_pkg::TURN_CYCLES - 1))
					begin
						// Core answer has settled by now, turnaround covers the crossing
						lOut   <= rdHold;
						sdaOut <= rdHold[15];
						sdaOe  <= 1'b1;
						lCnt   <= 5'h00;
						lState <= resc_pkg::LNK_RDATA;
					end
				end
				resc_pkg::LNK_RDATA:
				begin
					lCnt <= lCnt + 5'h01;
					lOut <= {lOut[14:0], 1'b0};
					sdaOut <= lOut[14];
					if (lCnt == 5'(resc_pkg::DATA_BITS - 1))
					begin
						sdaOut <= 1'b1;
						sdaOe  <= 1'b0;
						lState <= resc_pkg::LNK_IDLE;
					end
				end
				default:
					lState <= resc_pkg::LNK_IDLE;
			endcase
		end
	end

	// Slow inputs and link toggles cross in one synchroniser
	resc_sync3 #(
		.W(10)
	) u_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.din     ({rdTog, wrTog, tonModeStrap, inductorNearZero, voutBelowRamp,
			enableAboveStart, biasAboveStop, biasAboveStart}),
		.dout    (syncd)
	);
	wire sBiasStart = syncd[0];
	wire sBiasStop  = syncd[1];
	wire sEnable    = syncd[2];
	wire sTrigger   = syncd[3];
	wire sNearZero  = syncd[4];
	wire [2:0] sStrap = syncd[7:5];
	wire wrPulse = syncd[8] ^ wrTogD;
	wire rdPulse = syncd[9] ^ rdTogD;
	wire [15:0] busAddr = lHdr[15:0];

	// Frequency legality check
	function automatic logic resc_freq_ok(input logic [15:0] f);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < 8; i++)
			if (f == {5'h00, resc_pkg::FREQ_KHZ[i]})
				ok = 1'b1;
		return ok;
	endfunction : resc_freq_ok

	// Write decode, gated by bias good so a dying supply cannot corrupt settings
	wire wrEn     = wrPulse & biasOk;
	wire wrFreqOk = resc_freq_ok(lData);
	wire usePin   = ~regOvr[resc_pkg::OVR_TON_BIT] & ~regOvr[resc_pkg::OVR_FCCM_BIT];

	// Read selection
	logic [15:0] rdMux;
	always_comb
	begin
		case (busAddr)
			resc_pkg::ADDR_MODE:   rdMux = regMode;
			resc_pkg::ADDR_OVR:    rdMux = regOvr;
			resc_pkg::ADDR_DRCFG:  rdMux = regDrCfg;
			resc_pkg::ADDR_APD:    rdMux = regApd;
			resc_pkg::ADDR_OPER:   rdMux = {8'h00, regOper};
			resc_pkg::ADDR_ONOFF:  rdMux = {8'h00, regOnOff};
			resc_pkg::ADDR_DROOP:  rdMux = regDroop;
			resc_pkg::ADDR_FREQ:   rdMux = regFreq;
			resc_pkg::ADDR_TDELAY: rdMux = regTDelay;
			resc_pkg::ADDR_TRISE:  rdMux = regTRise;
			resc_pkg::ADDR_STATUS: rdMux = {8'h00, rampLevel[7:4], armed, held.fccm,
				seqState};
			resc_pkg::ADDR_VIN:    rdMux = tele.vin;
			resc_pkg::ADDR_IIN:    rdMux = tele.iin;
			resc_pkg::ADDR_VOUT:   rdMux = tele.vout;
			resc_pkg::ADDR_IOUT:   rdMux = tele.iout;
			resc_pkg::ADDR_TEMP:   rdMux = tele.temp;
			resc_pkg::ADDR_POUT:   rdMux = tele.pout;
			resc_pkg::ADDR_PIN:    rdMux = tele.pin;
			default:               rdMux = 16'h0000;
		endcase
	end

	// Register file
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			regMode   <= resc_pkg::RST_MODE;
			regOvr    <= resc_pkg::RST_OVR;
			regDrCfg  <= resc_pkg::RST_DRCFG;
			regApd    <= resc_pkg::RST_APD;
			regOper   <= resc_pkg::RST_OPER;
			regOnOff  <= resc_pkg::RST_ONOFF;
			regDroop  <= resc_pkg::RST_DROOP;
			regFreq   <= resc_pkg::RST_FREQ;
			regTDelay <= resc_pkg::RST_TDELAY;
			regTRise  <= resc_pkg::RST_TRISE;
			rdHold    <= 16'h0000;
			wrTogD    <= 1'b0;
			rdTogD    <= 1'b0;
		end
		else
		begin
			wrTogD <= syncd[8];
			rdTogD <= syncd[9];
			if (rdPulse)
				rdHold <= biasOk ? rdMux : 16'h0000;
			if (wrEn)
			begin
				case (busAddr)
					resc_pkg::ADDR_MODE:   regMode   <= lData;
					resc_pkg::ADDR_OVR:    regOvr    <= lData;
					resc_pkg::ADDR_DRCFG:  regDrCfg  <= lData;
					resc_pkg::ADDR_APD:    regApd    <= lData;
					resc_pkg::ADDR_OPER:   regOper   <= lData[7:0];
					resc_pkg::ADDR_ONOFF:  regOnOff  <= lData[7:0];
					resc_pkg::ADDR_DROOP:  regDroop  <= lData;
					resc_pkg::ADDR_TDELAY: regTDelay <= lData;
					resc_pkg::ADDR_TRISE:  regTRise  <= lData;
					resc_pkg::ADDR_FREQ:
						if (wrFreqOk)
							regFreq <= lData;
					default: ;
				endcase
			end
		end
	end

	// Enable source: pin and command as the source config asks
	wire needCmd = regOnOff[resc_pkg::ONOFF_CMD];
	wire needPin = regOnOff[resc_pkg::ONOFF_PIN];
	wire srcOn   = ~regOnOff[resc_pkg::ONOFF_RESP] |
		((~needCmd | regOper[resc_pkg::OPER_ON_BIT]) & (~needPin | sEnable));
	wire runReq  = biasOk & armed & srcOn;
	wire [31:0] delayTarget = 32'(regTDelay) * 32'(MS_CYC);
	wire [31:0] stepTarget  = 32'(regTRise) * 32'(RAMP_DIV);
	wire cntDone = seqCnt >= delayTarget;
	wire stepDone = seqCnt >= stepTarget;
	wire qualify = (seqState == resc_pkg::SEQ_OFF) & runReq;
	wire powerUp = biasOk & ~biasOkD;

	// Bias hysteresis and re-arm after a supply dip
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			biasOk  <= 1'b0;
			biasOkD <= 1'b0;
			armed   <= 1'b1;
		end
		else
		begin
			biasOkD <= biasOk;
			if (sBiasStart)
				biasOk <= 1'b1;
			else if (!sBiasStop)
				biasOk <= 1'b0;
			if (biasOkD & ~biasOk)
				armed <= 1'b0;
			else if (biasOk & ~sEnable)
				armed <= 1'b1;
		end
	end

	// Sequencer next state
	always_comb
	begin
		next_seqState = seqState;
		case (seqState)
			resc_pkg::SEQ_OFF:
				if (runReq)
					next_seqState = resc_pkg::SEQ_DELAY;
			resc_pkg::SEQ_DELAY:
				if (!runReq)
					next_seqState = resc_pkg::SEQ_OFF;
				else if (cntDone)
					next_seqState = resc_pkg::SEQ_RISE;
			resc_pkg::SEQ_RISE:
				if (!runReq)
					next_seqState = resc_pkg::SEQ_OFF;
				else if (stepDone && rampLevel == 8'hFF)
					next_seqState = resc_pkg::SEQ_ON;
			resc_pkg::SEQ_ON:
				if (!runReq)
					next_seqState = resc_pkg::SEQ_OFF;
			default:
				next_seqState = resc_pkg::SEQ_OFF;
		endcase
	end

	// Sequencer; ramp climbs one level per step
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			seqState  <= resc_pkg::SEQ_OFF;
			seqCnt    <= 32'h0000_0000;
			rampLevel <= 8'h00;
		end
		else
		begin
			seqState <= next_seqState;
			if (next_seqState != seqState || (seqState == resc_pkg::SEQ_RISE && stepDone))
				seqCnt <= 32'h0000_0000;
			else
				seqCnt <= seqCnt + 32'h0000_0001;
			if (next_seqState == resc_pkg::SEQ_OFF || seqState == resc_pkg::SEQ_DELAY)
				rampLevel <= 8'h00;
			else if (seqState == resc_pkg::SEQ_RISE && stepDone && rampLevel != 8'hFF)
				rampLevel <= rampLevel + 8'h01;
		end
	end

	// Output stays off through the delay; switching starts with the ramp
	assign switchEnable    = (seqState == resc_pkg::SEQ_RISE) | (seqState == resc_pkg::SEQ_ON);
	assign softStartActive = seqState == resc_pkg::SEQ_RISE;

	// Mode and frequency held from qualification on
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			held <= '0;
		end
		else if (qualify | powerUp)
		begin
			held.fccm   <= usePin ? resc_pkg::STRAP_FCCM[sStrap] : regMode[resc_pkg::MODE_FCCM_BIT];
			held.fswKhz <= usePin ? resc_pkg::FREQ_KHZ[sStrap] : regFreq[10:0];
		end
	end

	// On-time divider: Vo*fclk / (Vin*fsw), rerun without pause
	wire [28:0] remShift = {divRem[27:0], divNum[27]};
	wire        remGe    = remShift >= {6'h00, divDen};
	wire [27:0] quoFull  = {divQuo[26:0], remGe};
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			divNum       <= 28'h0000000;
			divDen       <= 23'h000000;
			divRem       <= 29'h00000000;
			divQuo       <= 28'h0000000;
			divCnt       <= 5'h00;
			onTimeCycles <= 16'h0001;
		end
		else if (divCnt == 5'h00)
		begin
			divNum <= 28'(voutSense * resc_pkg::CLK_KHZ);
			divDen <= 23'(vinSense * held.fswKhz);
			divRem <= 29'h00000000;
			divQuo <= 28'h0000000;
			divCnt <= 5'(resc_pkg::DIV_STEPS);
		end
		else
		begin
			divNum <= {divNum[26:0], 1'b0};
			divRem <= remGe ? remShift - {6'h00, divDen} : remShift;
			divQuo <= quoFull;
			divCnt <= divCnt - 5'h01;
			if (divCnt == 5'h01)
			begin
				if (divDen == 23'h000000 || quoFull[27:16] != 12'h000)
					onTimeCycles <= 16'hFFFF;
				else if (quoFull[15:0] == 16'h0000)
					onTimeCycles <= 16'h0001;
				else
					onTimeCycles <= quoFull[15:0];
			end
		end
	end

	// Fixed on-time pulse and synchronous switch control
	wire startPulse = switchEnable & ~highSideOn & sTrigger;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			highSideOn <= 1'b0;
			lowSideOn  <= 1'b0;
			hsCnt      <= 16'h0000;
		end
		else
		begin
			if (!switchEnable)
				highSideOn <= 1'b0;
			else if (startPulse)
			begin
				highSideOn <= 1'b1;
				hsCnt      <= onTimeCycles;
			end
			else if (highSideOn)
			begin
				hsCnt <= hsCnt - 16'h0001;
				if (hsCnt <= 16'h0001)
					highSideOn <= 1'b0;
			end
			lowSideOn <= switchEnable & ~highSideOn & ~startPulse &
				(held.fccm | ~sNearZero);
		end
	end

	// Load-line settings, clamped to the selected range
	wire [15:0] droopMax = regDrCfg[resc_pkg::DR_RANGE_BIT] ?
		resc_pkg::DROOP_MAX_WIDE : resc_pkg::DROOP_MAX_NARROW;
	wire [3:0] bwField = regDrCfg[3:0];
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			droopCode    <= 16'h0000;
			droopWide    <= 1'b0;
			droopBwKhz   <= 9'h000;
			analogStayOn <= 1'b0;
		end
		else
		begin
			droopCode    <= (regDroop > droopMax) ? droopMax : regDroop;
			droopWide    <= regDrCfg[resc_pkg::DR_RANGE_BIT];
			droopBwKhz   <= 9'(({5'h00, bwField} + 9'h001) * resc_pkg::BW_STEP_KHZ);
			analogStayOn <= regApd == resc_pkg::PREBIAS_KEEP;
		end
	end
endmodule : resc_startup_config
`default_nettype wire

/* resc_pkg.sv */
// Constants and types for the regulator enable, start-up and configuration block
package resc_pkg;
	// Register offsets on the management link
	localparam logic [15:0] ADDR_MODE    = 16'h005C;
	localparam logic [15:0] ADDR_OVR     = 16'h005E;
	localparam logic [15:0] ADDR_DRCFG   = 16'h006A;
	localparam logic [15:0] ADDR_APD     = 16'h006C;
	localparam logic [15:0] ADDR_OPER    = 16'h0202;
	localparam logic [15:0] ADDR_ONOFF   = 16'h0204;
	localparam logic [15:0] ADDR_DROOP   = 16'h0250;
	localparam logic [15:0] ADDR_FREQ    = 16'h0266;
	localparam logic [15:0] ADDR_TDELAY  = 16'h0260;
	localparam logic [15:0] ADDR_TRISE   = 16'h0261;
	localparam logic [15:0] ADDR_STATUS  = 16'h0279;
	localparam logic [15:0] ADDR_VIN     = 16'h0288;
	localparam logic [15:0] ADDR_IIN     = 16'h0289;
	localparam logic [15:0] ADDR_VOUT    = 16'h028B;
	localparam logic [15:0] ADDR_IOUT    = 16'h028C;
	localparam logic [15:0] ADDR_TEMP    = 16'h028D;
	localparam logic [15:0] ADDR_POUT    = 16'h0296;
	localparam logic [15:0] ADDR_PIN     = 16'h0297;
	// Field positions
	localparam int MODE_FCCM_BIT = 1;
	localparam int OVR_TON_BIT   = 4;
	localparam int OVR_FCCM_BIT  = 5;
	localparam int DR_RANGE_BIT  = 6;
	localparam int ONOFF_RESP    = 4;
	localparam int ONOFF_CMD     = 3;
	localparam int ONOFF_PIN     = 2;
	localparam int OPER_ON_BIT   = 7;
	// Values after reset
	localparam logic [15:0] RST_MODE   = 16'h0000;
	localparam logic [15:0] RST_OVR    = 16'h0030;
	localparam logic [15:0] RST_DRCFG  = 16'h0000;
	localparam logic [15:0] RST_APD    = 16'h0000;
	localparam logic [7:0]  RST_OPER   = 8'h00;
	localparam logic [7:0]  RST_ONOFF  = 8'h14;
	localparam logic [15:0] RST_DROOP  = 16'h0000;
	localparam logic [15:0] RST_FREQ   = 16'h0320;
	localparam logic [15:0] RST_TDELAY = 16'h0000;
	localparam logic [15:0] RST_TRISE  = 16'h0005;
	localparam logic [15:0] PREBIAS_KEEP = 16'hF240;
	// Load-line limits in codes: 10 mOhm / 19.53 uOhm and 50 mOhm / 100 uOhm
	localparam logic [15:0] DROOP_MAX_NARROW = 16'h0200;
	localparam logic [15:0] DROOP_MAX_WIDE   = 16'h01F4;
	localparam logic [8:0]  BW_STEP_KHZ      = 9'h01E;
	// Allowed switching frequencies in kHz, also the strap table
	localparam logic [10:0] FREQ_KHZ [0:7] = '{11'd400, 11'd600, 11'd800, 11'd1000,
		11'd1200, 11'd1400, 11'd1800, 11'd2000};
	localparam logic [7:0] STRAP_FCCM = 8'hF0;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int RAMP_STEPS = 256;
	localparam logic [15:0] CLK_KHZ = 16'(CLK_HZ / 1000);
	localparam int DIV_STEPS = 28;
	localparam int HDR_BITS = 17;
	localparam int DATA_BITS = 16;
	localparam int TURN_CYCLES = 16;
	// Telemetry words from the monitor
	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] iin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] pin;
		logic [15:0] pout;
		logic [15:0] temp;
	} resc_tele_t;
	// Configuration held between enable cycles
	typedef struct packed {
		logic        fccm;
		logic [10:0] fswKhz;
	} resc_latch_t;
	typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON} resc_seq_t;
	typedef enum logic [2:0] {LNK_IDLE, LNK_HDR, LNK_WDATA, LNK_TURN, LNK_RDATA} resc_lnk_t;
endpackage : resc_pkg

/* resc_startup_props.sv */
// Concurrent checks on the start-up block ports
`timescale 1ns/100ps
`default_nettype none
module resc_startup_props (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire logic                  biasAboveStop,
	input wire logic                  inductorNearZero,
	input wire logic                  switchEnable,
	input wire logic                  softStartActive,
	input wire logic [7:0]            rampLevel,
	input wire logic                  highSideOn,
	input wire logic                  lowSideOn,
	input wire logic [15:0]           onTimeCycles,
	input wire resc_pkg::resc_latch_t held,
	input wire logic [15:0]           droopCode,
	input wire logic                  droopWide,
	input wire logic [8:0]            droopBwKhz
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (rst);
	// Six cycles cover the input synchroniser
	sequence s_dem_idle;
		(inductorNearZero && !held.fccm)[*6];
	endsequence
	sequence s_fccm_gap;
		(switchEnable && !highSideOn && held.fccm)[*2];
	endsequence
	sequence s_pulse_start;
		$rose(highSideOn) && $past(onTimeCycles) > 16'h0003;
	endsequence
	// Sequencer and soft-start ramp
	property p_ss_in_run; $rose(softStartActive) |-> rampLevel == 8'h00; endproperty
	property p_ramp_idle; !switchEnable[*2] |-> rampLevel == 8'h00; endproperty
	property p_ramp_up;
		softStartActive && $past(softStartActive) |-> rampLevel >= $past(rampLevel);
	endproperty
	property p_bias_lost; !biasAboveStop[*8] |-> !switchEnable; endproperty
	a_ss_in_run: assert property (p_ss_in_run) else $error("ramp start");
	a_ramp_idle: assert property (p_ramp_idle) else $error("ramp while idle");
	a_ramp_up: assert property (p_ramp_up) else $error("ramp fell");
	a_bias_lost: assert property (p_bias_lost) else $error("run without bias");
	// Switch drive
	property p_hs_run; $rose(highSideOn) |-> $past(switchEnable); endproperty
	property p_hs_width; s_pulse_start |-> highSideOn[*3]; endproperty
	property p_fccm_ls; s_fccm_gap |-> lowSideOn; endproperty
	property p_dem_ls; s_dem_idle |-> !lowSideOn; endproperty
	a_hs_run: assert property (p_hs_run) else $error("pulse while stopped");
	a_hs_width: assert property (p_hs_width) else $error("pulse too short");
	a_fccm_ls: assert property (p_fccm_ls) else $error("sync switch off");
	a_dem_ls: assert property (p_dem_ls) else $error("sync switch on");
	// Load-line outputs
	property p_droop_max;
		$stable(droopWide)[*3] |-> droopCode <= (droopWide ? 16'h01F4 : 16'h0200);
	endproperty
	property p_bw_step;
		droopBwKhz != 9'h000 |-> droopBwKhz % 9'h01E == 9'h000 && droopBwKhz <= 9'h1E0;
	endproperty
	a_droop_max: assert property (p_droop_max) else $error("droop over range");
	a_bw_step: assert property (p_bw_step) else $error("bad bandwidth");
endmodule : resc_startup_props
bind resc_startup_config resc_startup_props u_props (.core_clk, .rst, .biasAboveStop,
	.inductorNearZero, .switchEnable, .softStartActive, .rampLevel, .highSideOn, .lowSideOn,
	.onTimeCycles, .held, .droopCode, .droopWide, .droopBwKhz);
`default_nettype wire

/* resc_host_model.sv */
// Management host model driving the two-wire link
`timescale 1ns/100ps
`default_nettype none
module resc_host_model (
	output var  logic linkClk,
	output wire logic sdaIn,
	input  wire logic sdaOut,
	input  wire logic sdaOe
);
	logic        hostBit = 1'b1;
	logic        hostOe = 1'b1;
	logic [15:0] readWord = 16'h0000;
	int          readCount = 0;
	initial linkClk = 1'b0;
	// Pulled-up data line: released means high
	assign sdaIn = sdaOe ? sdaOut : (hostOe ? hostBit : 1'b1);
	// One link clock; clock rests low between frames
	task automatic tick(input logic d, input logic oe, output logic s);
		hostBit = d;
		hostOe = oe;
		#7.5 s = sdaIn;
		linkClk = 1'b1;
		#7.5 linkClk = 1'b0;
	endtask : tick
	// Start, header, then data or turnaround and read
	task automatic frame(input logic rw, input logic [15:0] a, input logic [15:0] d);
		logic        s;
		logic [15:0] got;
		tick(1'b0, 1'b1, s);
		tick(rw, 1'b1, s);
		for (int i = 15; i >= 0; i--) tick(a[i], 1'b1, s);
		for (int i = 15; i >= 0; i--) tick(rw | d[i], !rw, s);
		for (int i = 15; i >= 0; i--)
		begin
			if (rw) tick(1'b1, 1'b0, s);
			got[i] = s;
		end
		// Idle high edge, then room for the core crossing
		tick(1'b1, 1'b1, s);
		#300;
		if (rw)
		begin
			readWord = got;
			readCount++;
		end
	endtask : frame
endmodule : resc_host_model
`default_nettype wire

/* resc_startup_config_tb_top.sv */
// Self-checking bench for the start-up and configuration block
`timescale 1ns/100ps
`default_nettype none
module resc_startup_config_tb_top;
	typedef struct {string what; logic [15:0] exp;} resc_note_t;
	localparam logic [15:0] RA [0:5] = '{resc_pkg::ADDR_MODE, resc_pkg::ADDR_OVR,
		resc_pkg::ADDR_ONOFF, resc_pkg::ADDR_FREQ, resc_pkg::ADDR_TRISE, 16'h0100};
	localparam logic [15:0] RE [0:5] = '{resc_pkg::RST_MODE, resc_pkg::RST_OVR,
		16'h0014, resc_pkg::RST_FREQ, resc_pkg::RST_TRISE, 16'h0000};
	logic core_clk, rst, linkClk, sdaIn, sdaOut, sdaOe, biasAboveStart, biasAboveStop;
	logic enableAboveStart, voutBelowRamp, inductorNearZero, switchEnable, softStartActive;
	logic highSideOn, lowSideOn, droopWide, analogStayOn;
	logic [2:0] tonModeStrap;
	logic [11:0] voutSense, vinSense;
	logic [7:0] rampLevel;
	logic [15:0] onTimeCycles, droopCode, v, cur, portVal;
	logic [8:0] droopBwKhz;
	logic [127:0] rnd;
	resc_pkg::resc_tele_t tele;
	resc_pkg::resc_latch_t held;
	resc_note_t notes [$];
	event portTick;
	int failures = 0, samples_checked = 0, seed = 64;
	resc_startup_config #(.MS_CYC(512)) u_dut (.core_clk, .rst, .linkClk, .sdaIn, .sdaOut,
		.sdaOe, .biasAboveStart, .biasAboveStop, .enableAboveStart, .voutBelowRamp,
		.inductorNearZero, .tonModeStrap, .voutSense, .vinSense, .tele, .switchEnable,
		.softStartActive, .rampLevel, .highSideOn, .lowSideOn, .onTimeCycles, .held,
		.droopCode, .droopWide, .droopBwKhz, .analogStayOn);
	resc_host_model u_host (.linkClk, .sdaIn, .sdaOut, .sdaOe);
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Oldest note meets each result
	task automatic judge(input logic [15:0] got);
		resc_note_t n;
		n = notes.pop_front();
		samples_checked++;
		if (got !== n.exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n.what, n.exp, got);
		end
	endtask : judge
	always @(portTick) judge(portVal);
	always @(u_host.readCount) judge(u_host.readWord);
	task automatic look(input string w, input logic [15:0] e, input logic [15:0] g);
		notes.push_back('{w, e});
		portVal = g;
		->portTick;
		#0;
	endtask : look
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		notes.push_back('{$sformatf("reg %h", a), e});
		u_host.frame(1'b1, a, 16'h0000);
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_host.frame(1'b0, a, d);
	endtask : wr
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : cyc
	// Bounded wait for a level
	task automatic await(ref logic s, input logic e, input int lim);
		int k;
		k = 0;
		while (s !== e && k < lim)
		begin
			@(posedge core_clk);
			k++;
		end
		#2;
		if (s !== e)
		begin
			failures++;
			$display("Error wait expected %b seen %b", e, s);
			give_verdict();
		end
	endtask : await
	task automatic give_verdict;
		$display("Checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		#1_000_000;
		failures++;
		give_verdict();
	end
	// Main sequence
	initial
	begin
		rst = 1'b1;
		{biasAboveStart, biasAboveStop, enableAboveStart, voutBelowRamp} = 4'h0;
		inductorNearZero = 1'b0;
		tonModeStrap = 3'h0;
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
		tele = rnd[111:0];
		vinSense = 12'($random(seed)) | 12'h800;
		voutSense = (12'($random(seed)) & 12'h3FF) | 12'h200;
		cyc(4);
		rst = 1'b0;
		wr(resc_pkg::ADDR_MODE, 16'h0002);
		{biasAboveStart, biasAboveStop} = 2'h3;
		cyc(10);
		for (int i = 0; i < 6; i++) rd(RA[i], RE[i]);
		rd(resc_pkg::ADDR_VIN, tele.vin);
		rd(resc_pkg::ADDR_TEMP, tele.temp);
		cur = resc_pkg::RST_FREQ;
		for (int i = 0; i < 7; i++)
		begin
			v = (i == 0) ? 16'h0640 : 16'(200 * (1 + $unsigned($random(seed)) % 11));
			wr(resc_pkg::ADDR_FREQ, v);
			if (v >= 16'h0190 && v <= 16'h07D0 && v != 16'h0640) cur = v;
			rd(resc_pkg::ADDR_FREQ, cur);
		end
		wr(resc_pkg::ADDR_FREQ, 16'h03E8);
		wr(resc_pkg::ADDR_DROOP, 16'h0300);
		look("droopCode", 16'h0200, droopCode);
		wr(resc_pkg::ADDR_DRCFG, 16'h004F);
		look("droopWide", 16'h0001, 16'(droopWide));
		look("droopCode", 16'h01F4, droopCode);
		look("droopBwKhz", 16'h01E0, 16'(droopBwKhz));
		wr(resc_pkg::ADDR_APD, resc_pkg::PREBIAS_KEEP);
		look("analogStayOn", 16'h0001, 16'(analogStayOn));
		wr(resc_pkg::ADDR_MODE, 16'h0002);
		wr(resc_pkg::ADDR_TDELAY, 16'h0001);
		wr(resc_pkg::ADDR_TRISE, 16'h0001);
		enableAboveStart = 1'b1;
		cyc(20);
		look("fccm", 16'h0001, 16'(held.fccm));
		look("fswKhz", 16'h03E8, 16'(held.fswKhz));
		cyc(400);
		look("switchEnable", 16'h0000, 16'(switchEnable));
		await(switchEnable, 1'b1, 300);
		look("softStartActive", 16'h0001, 16'(softStartActive));
		await(softStartActive, 1'b0, 1200);
		look("rampLevel", 16'h00FF, 16'(rampLevel));
		look("onTime", 16'(voutSense * resc_pkg::CLK_KHZ / 1000 / vinSense), onTimeCycles);
		voutBelowRamp = 1'b1;
		await(highSideOn, 1'b1, 20);
		voutBelowRamp = 1'b0;
		wr(resc_pkg::ADDR_MODE, 16'h0000);
		look("fccm", 16'h0001, 16'(held.fccm));
		enableAboveStart = 1'b0;
		cyc(10);
		look("switchEnable", 16'h0000, 16'(switchEnable));
		enableAboveStart = 1'b1;
		inductorNearZero = 1'b1;
		cyc(20);
		look("fccm", 16'h0000, 16'(held.fccm));
		wr(resc_pkg::ADDR_ONOFF, 16'h0018);
		cyc(600);
		look("switchEnable", 16'h0000, 16'(switchEnable));
		wr(resc_pkg::ADDR_OPER, 16'h0080);
		await(switchEnable, 1'b1, 700);
		wr(resc_pkg::ADDR_ONOFF, 16'h0014);
		{biasAboveStart, biasAboveStop} = 2'h0;
		cyc(10);
		look("switchEnable", 16'h0000, 16'(switchEnable));
		{biasAboveStart, biasAboveStop} = 2'h3;
		cyc(800);
		look("switchEnable", 16'h0000, 16'(switchEnable));
		wr(resc_pkg::ADDR_OVR, 16'h0000);
		tonModeStrap = 3'h5;
		enableAboveStart = 1'b0;
		cyc(10);
		enableAboveStart = 1'b1;
		cyc(20);
		tonModeStrap = 3'h2;
		cyc(20);
		look("fswKhz", 16'(resc_pkg::FREQ_KHZ[5]), 16'(held.fswKhz));
		look("fccm", 16'h0001, 16'(held.fccm));
		await(switchEnable, 1'b1, 700);
		give_verdict();
	end
endmodule : resc_startup_config_tb_top
`default_nettype wire
